// File: logic/output_register_write_guard.sv
// top: avalon-mm slave holding guarded pin and fault control registers
// assumes the lock fuse level may change freely; it is synchronised here
`timescale 1ns/1ps
module output_register_write_guard #(
  parameter int NUM_CH = wguard_pkg::NUM_CH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] oscillator_select_config_word,
  input wire logic [wguard_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NUM_CH*16-1:0] output_pin_control_reg,
  output logic [NUM_CH*16-1:0] fault_current_limit_reg,
  output logic unlock_open
);

  // ************************************************************
  // request capture and single-wait handshake
  // ************************************************************
  wguard_pkg::bus_req_s req;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic lock_ff;
  logic [1:0] seq_state;
  logic [15:0] pin_ff [NUM_CH];
  logic [15:0] flt_ff [NUM_CH];

  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;
  assign req.byteenable = avs_byteenable;

  wire logic req_on = req.read || req.write;
  wire logic acc_fire = req_on && ack_ff;
  wire logic wr_fire = acc_fire && req.write;
  wire logic key_hit = req.address == wguard_pkg::OFS_KEY;
  wire logic stat_hit = req.address == wguard_pkg::OFS_STATUS;
  wire logic [15:0] wdata16 = req.writedata[15:0];
  wire logic wr_allowed = !lock_ff || unlock_open;

  assign avs_waitrequest = req_on && !ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= req_on && !ack_ff;
  end

  // ************************************************************
  // lock fuse synchroniser and lock state
  // ************************************************************
  logic fuse_s1_ff;
  logic fuse_s2_ff;
  logic fuse_s3_ff;
  wire logic fuse_pin =
    oscillator_select_config_word[wguard_pkg::FUSE_LOCK_BIT];
  wire logic fuse_agree = fuse_s2_ff == fuse_s3_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fuse_s1_ff <= wguard_pkg::FUSE_DEFAULT;
      fuse_s2_ff <= wguard_pkg::FUSE_DEFAULT;
      fuse_s3_ff <= wguard_pkg::FUSE_DEFAULT;
    end
    else
    begin
      fuse_s1_ff <= fuse_pin;
      fuse_s2_ff <= fuse_s1_ff;
      fuse_s3_ff <= fuse_s2_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lock_ff <= wguard_pkg::FUSE_DEFAULT;
    else if (fuse_agree)
      lock_ff <= fuse_s3_ff;
  end

  unlock_sequencer u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .acc_fire(acc_fire),
    .acc_key_wr(wr_fire && key_hit),
    .acc_wdata(wdata16),
    .open(unlock_open),
    .state(seq_state)
  );

  // ************************************************************
  // guarded registers per channel
  // ************************************************************
  logic [NUM_CH-1:0] pin_hit;
  logic [NUM_CH-1:0] flt_hit;

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    assign pin_hit[i] = req.address ==
      6'(wguard_pkg::OFS_PIN_BASE + 6'(4 * i));
    assign flt_hit[i] = req.address ==
      6'(wguard_pkg::OFS_FLT_BASE + 6'(4 * i));
    wire logic [15:0] pin_new = {
      req.byteenable[1] ? wdata16[15:8] : pin_ff[i][15:8],
      req.byteenable[0] ? wdata16[7:0] : pin_ff[i][7:0]};
    wire logic [15:0] flt_new = {
      req.byteenable[1] ? wdata16[15:8] : flt_ff[i][15:8],
      req.byteenable[0] ? wdata16[7:0] : flt_ff[i][7:0]};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_ff[i] <= wguard_pkg::PIN_RESET;
        flt_ff[i] <= wguard_pkg::FLT_RESET;
      end
      else
      begin
        if (wr_fire && pin_hit[i] && wr_allowed)
          pin_ff[i] <= pin_new;
        if (wr_fire && flt_hit[i] && wr_allowed)
          flt_ff[i] <= flt_new;
      end
    end

    assign output_pin_control_reg[i*16 +: 16] = pin_ff[i];
    assign fault_current_limit_reg[i*16 +: 16] = flt_ff[i];

    // ************************************************************
    // per-channel guard checks
    // ************************************************************
    AST_PIN_GUARD: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && pin_hit[i] && lock_ff && !unlock_open)
      |=> $stable(pin_ff[i]))
      else $error("locked pin register changed");
    AST_FLT_GUARD: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && flt_hit[i] && lock_ff && !unlock_open)
      |=> $stable(flt_ff[i]))
      else $error("locked fault register changed");
    AST_FUSE_OFF_WRITE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && pin_hit[i] && !lock_ff && req.byteenable[1:0] == 2'b11)
      |=> pin_ff[i] == $past(wdata16))
      else $error("unlocked write not stored");
    AST_FLT_FUSE_OFF_WRITE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && flt_hit[i] && !lock_ff && req.byteenable[1:0] == 2'b11)
      |=> flt_ff[i] == $past(wdata16))
      else $error("unlocked fault write not stored");
    AST_PIN_GRANT_WRITE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && pin_hit[i] && unlock_open && req.byteenable[1:0] == 2'b11)
      |=> pin_ff[i] == $past(wdata16))
      else $error("granted pin write not stored");
    AST_FLT_GRANT_WRITE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && flt_hit[i] && unlock_open && req.byteenable[1:0] == 2'b11)
      |=> flt_ff[i] == $past(wdata16))
      else $error("granted fault write not stored");
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb
  begin
    nxt_rdata = wguard_pkg::UNMAPPED_READ;
    if (stat_hit)
      nxt_rdata = {29'h0, seq_state, lock_ff};
    for (int k = 0; k < NUM_CH; k++)
    begin
      if (pin_hit[k])
        nxt_rdata = {16'h0, pin_ff[k]};
      if (flt_hit[k])
        nxt_rdata = {16'h0, flt_ff[k]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= wguard_pkg::UNMAPPED_READ;
    else if (req.read && !ack_ff)
      rdata_ff <= nxt_rdata;
  end

  // ************************************************************
  // handshake, read and lock checks
  // ************************************************************
  AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(req_on) && !ack_ff) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not released after one cycle");
  AST_ACK_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ack_ff |=> !ack_ff)
    else $error("acknowledge held for two cycles");
  AST_READ_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.read && !ack_ff) |=> avs_readdata == $past(nxt_rdata))
    else $error("read data not captured");
  AST_UNMAPPED_READ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (req.read && !ack_ff && !stat_hit && !(|pin_hit) && !(|flt_hit))
    |=> avs_readdata == wguard_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  AST_FUSE_TRACK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    fuse_agree |=> lock_ff == $past(fuse_s3_ff))
    else $error("lock does not follow fuse bit");

endmodule : output_register_write_guard

// File: logic/unlock_sequencer.sv
// unlock key sequencer: tracks the key pair and grants one guarded write
// assumes one pulse per accepted register access from the bus slave
`timescale 1ns/1ps
module unlock_sequencer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic acc_fire,
  input wire logic acc_key_wr,
  input wire logic [15:0] acc_wdata,
  output logic open,
  output logic [1:0] state
);

  wguard_pkg::seq_state_e state_ff;
  wguard_pkg::seq_state_e nxt_state;

  wire logic key1_ok = acc_key_wr && acc_wdata == wguard_pkg::KEY_FIRST;
  wire logic key2_ok = acc_key_wr && acc_wdata == wguard_pkg::KEY_SECOND;

  always_comb
  begin
    nxt_state = state_ff;
    if (acc_fire)
    begin
      unique case (state_ff)
        wguard_pkg::SEQ_IDLE:
          nxt_state = key1_ok ? wguard_pkg::SEQ_KEY1
                    : wguard_pkg::SEQ_IDLE;
        wguard_pkg::SEQ_KEY1:
          nxt_state = key2_ok ? wguard_pkg::SEQ_OPEN
                    : key1_ok ? wguard_pkg::SEQ_KEY1
                    : wguard_pkg::SEQ_IDLE;
        wguard_pkg::SEQ_OPEN:
          nxt_state = key1_ok ? wguard_pkg::SEQ_KEY1
                    : wguard_pkg::SEQ_IDLE;
        default:
          nxt_state = wguard_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= wguard_pkg::SEQ_IDLE;
    else
      state_ff <= nxt_state;
  end

  assign open = state_ff == wguard_pkg::SEQ_OPEN;
  assign state = state_ff;

  AST_OPEN_AFTER_KEYS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (acc_fire && state_ff == wguard_pkg::SEQ_KEY1 && key2_ok) |=> open)
    else $error("unlock not opened after second key");
  AST_OPEN_ONE_ACCESS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (open && acc_fire) |=> !open)
    else $error("unlock survived an access");
  AST_WRONG_KEY_IDLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (acc_fire && !key1_ok && !(state_ff == wguard_pkg::SEQ_KEY1 && key2_ok))
    |=> state_ff == wguard_pkg::SEQ_IDLE)
    else $error("sequencer not idle after wrong access");
  AST_OPEN_ONLY_FROM_KEY1: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(open) |-> $past(state_ff) == wguard_pkg::SEQ_KEY1)
    else $error("unlock opened without first key");

endmodule : unlock_sequencer

// File: logic/wguard_pkg.sv
// package: register map, key values and bus carrier for the output write guard
// assumes an avalon-mm slave with 16-bit registers in 32-bit words
//
// Behaviour
// - every output pin control and fault/current-limit register is write guarded.
// - while locked, a guarded write without fresh unlock is ignored, contents kept.
// - protection is chosen by a fuse bit at bit 6 of the oscillator config word.
// - fuse bit at 1, the default, means protection is on.
// - fuse bit at 0 lets guarded registers be written directly.
// - only the register access right after the second key write is granted.
// - any other register access inside the sequence abandons the unlock.
// - each unlock grants exactly one guarded write.
package wguard_pkg;

  localparam int ADDR_W = 6;
  localparam int NUM_CH = 3;

  // ************************************************************
  // byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_KEY = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_BASE = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_FLT_BASE = 6'h20;

  // ************************************************************
  // keys, fuse position, reset values
  // ************************************************************
  localparam logic [15:0] KEY_FIRST = 16'habcd;
  localparam logic [15:0] KEY_SECOND = 16'h4321;
  localparam int FUSE_LOCK_BIT = 6;
  localparam logic FUSE_DEFAULT = 1'b1;
  localparam logic [15:0] PIN_RESET = 16'h0000;
  localparam logic [15:0] FLT_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_KEY1 = 2'b01,
    SEQ_OPEN = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_req_s;

endpackage : wguard_pkg

// File: test/output_register_write_guard_test.sv
// testbench for the output write guard: random and corner accesses
// assumes wguard_pkg and the guard top are compiled before it
`timescale 1ns/1ps
module output_register_write_guard_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] osc_word = 16'h0040;
  logic [wguard_pkg::ADDR_W-1:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wait_req;
  logic [47:0] pin_q;
  logic [47:0] flt_q;
  logic open_q;
  logic [15:0] exp_q [6];
  logic [31:0] got;
  int mismatches = 0;
  int tests_run = 0;

  always #12.5 ref_clk = ~ref_clk;

  output_register_write_guard i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .oscillator_select_config_word(osc_word),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .output_pin_control_reg(pin_q), .fault_current_limit_reg(flt_q),
    .unlock_open(open_q)
  );

  // ************************************************************
  // bus tasks and helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic access(input logic w, input logic [5:0] a,
                        input logic [31:0] d);
    int n;
    logic wq;
    @(posedge ref_clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    wq = 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(negedge ref_clk);
      wq = wait_req;
      got = rdata;
      @(posedge ref_clk);
      if (wq === 1'b0)
        break;
    end
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 16)
    begin
      mismatches++;
      wrap_up();
    end
  endtask : access

  task automatic key(input logic [15:0] k);
    access(1'b1, wguard_pkg::OFS_KEY, {16'h0000, k});
    @(negedge ref_clk);
  endtask : key

  function automatic logic [5:0] reg_adr(input int i);
    if (i < 3)
      return wguard_pkg::OFS_PIN_BASE + 6'(4 * i);
    return wguard_pkg::OFS_FLT_BASE + 6'(4 * (i - 3));
  endfunction : reg_adr

  function automatic logic [15:0] reg_now(input int i);
    return (i < 3) ? pin_q[16*i +: 16] : flt_q[16*(i-3) +: 16];
  endfunction : reg_now

  task automatic gwr(input int i, input logic take);
    logic [15:0] d;
    logic [1:0] b;
    d = 16'($urandom);
    b = (i % 3 == 0) ? 2'b11 : 2'($urandom);
    @(posedge ref_clk);
    be <= {2'b00, b};
    access(1'b1, reg_adr(i), {16'h0000, d});
    if (take && b[0])
      exp_q[i][7:0] = d[7:0];
    if (take && b[1])
      exp_q[i][15:8] = d[15:8];
    repeat (2) @(negedge ref_clk);
    check(reg_now(i), exp_q[i]);
    access(1'b0, reg_adr(i), 32'h0000_0000);
    check(got, {16'h0000, exp_q[i]});
  endtask : gwr

  task automatic rst();
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (exp_q[i])
      exp_q[i] = (i < 3) ? wguard_pkg::PIN_RESET : wguard_pkg::FLT_RESET;
  endtask : rst

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(69454));
    rst();
    @(negedge ref_clk);
    check(open_q, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      check(reg_now(i), wguard_pkg::FLT_RESET);
      gwr(i, 1'b0);
      key(wguard_pkg::KEY_FIRST);
      key(wguard_pkg::KEY_SECOND);
      check(open_q, 1'b1);
      gwr(i, 1'b1);
      gwr(i, 1'b0);
    end
    for (int i = 0; i < 2; i++)
    begin
      key(wguard_pkg::KEY_FIRST);
      if (i == 0)
      begin
        access(1'b0, wguard_pkg::OFS_STATUS, 32'h0000_0000);
        check(got[2:1], wguard_pkg::SEQ_KEY1);
      end
      key(wguard_pkg::KEY_SECOND);
      if (i == 1)
      begin
        access(1'b0, wguard_pkg::OFS_STATUS, 32'h0000_0000);
        check(got[2:1], wguard_pkg::SEQ_OPEN);
      end
      gwr(i, 1'b0);
    end
    key(wguard_pkg::KEY_FIRST);
    key(16'($urandom_range(255)));
    key(wguard_pkg::KEY_SECOND);
    gwr(3, 1'b0);
    key(wguard_pkg::KEY_FIRST);
    key(wguard_pkg::KEY_SECOND);
    @(posedge ref_clk);
    rst();
    gwr(4, 1'b0);
    access(1'b0, wguard_pkg::OFS_STATUS, 32'h0000_0000);
    check(got[0], 1'b1);
    access(1'b0, 6'h3c, 32'h0000_0000);
    check(got, wguard_pkg::UNMAPPED_READ);
    osc_word <= 16'($urandom) & 16'hffbf;
    repeat (6) @(posedge ref_clk);
    access(1'b0, wguard_pkg::OFS_STATUS, 32'h0000_0000);
    check(got[0], 1'b0);
    for (int i = 0; i < 6; i++)
      gwr(i, 1'b1);
    osc_word <= 16'($urandom) | 16'h0040;
    repeat (6) @(posedge ref_clk);
    gwr(5, 1'b0);
    for (int n = 0; n < 16; n++)
    begin
      if ($urandom_range(1) == 1)
      begin
        key(wguard_pkg::KEY_FIRST);
        key(wguard_pkg::KEY_SECOND);
        gwr($urandom_range(5), 1'b1);
      end
      else
        gwr($urandom_range(5), 1'b0);
    end
    wrap_up();
  end
endmodule : output_register_write_guard_test
